// [src/pses_evsel_qual.sv]
// Thread and privilege qualification of events by the event selector.
`timescale 1ns/1ps
module pses_evsel_qual #(
   parameter logic [15:0] THREAD_INDEP_MASK = 16'h0000
) (
   input  wire logic [31:0] evsel,
   input  wire logic        ev_valid,
   input  wire logic [5:0]  ev_class,
   input  wire logic [15:0] ev_sub,
   input  wire logic        ev_thread,
   input  wire logic [1:0]  ev_priv,
   output logic             count_hit
);
   import pses_pkg::*;

   logic        kernel;
   logic        thr_ok;
   logic        any_qual;
   logic        class_ok;
   logic [15:0] hits;

   assign kernel   = (ev_priv == 2'h0);
   always_comb begin
      if (ev_thread) begin
         thr_ok = kernel ? evsel[PSES_T1_KERNEL_BIT]
                         : evsel[PSES_T1_USER_BIT];
      end else begin
         thr_ok = kernel ? evsel[PSES_T0_KERNEL_BIT]
                         : evsel[PSES_T0_USER_BIT];
      end
   end
   assign any_qual = |evsel[PSES_T0_KERNEL_BIT:PSES_T1_USER_BIT];
   assign class_ok = (ev_class == evsel[PSES_CLASS_MSB:PSES_CLASS_LSB]);
   assign hits     = ev_sub & evsel[PSES_MASK_MSB:PSES_MASK_LSB];

   // Thread-independent sub-events only need some qualifier bit set.
   assign count_hit = ev_valid & class_ok &
                      ((thr_ok & (|hits)) |
                       (any_qual & (|(hits & THREAD_INDEP_MASK))));

endmodule

// [src/pses_pkg.sv]
// Package of constants for the precise sampling and event select block.
package pses_pkg;

   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] PSES_OFF_EVSEL     = 8'h00;
   localparam logic [7:0] PSES_OFF_SMP_EN    = 8'h04;
   localparam logic [7:0] PSES_OFF_MISC_EN   = 8'h08;
   localparam logic [7:0] PSES_OFF_AREA_PTR  = 8'h0c;
   localparam logic [7:0] PSES_OFF_COUNTER   = 8'h10;
   localparam logic [7:0] PSES_OFF_CNT_RST   = 8'h14;
   localparam logic [7:0] PSES_OFF_BUF_BASE  = 8'h18;
   localparam logic [7:0] PSES_OFF_BUF_INDEX = 8'h1c;
   localparam logic [7:0] PSES_OFF_BUF_MAX   = 8'h20;
   localparam logic [7:0] PSES_OFF_BUF_THR   = 8'h24;
   localparam logic [7:0] PSES_OFF_STATUS    = 8'h28;
   localparam logic [7:0] PSES_OFF_ID_FEAT   = 8'h2c;

   // ---------------------------------------------------------------
   // Event select control fields
   // ---------------------------------------------------------------
   localparam int PSES_T1_USER_BIT   = 0;
   localparam int PSES_T1_KERNEL_BIT = 1;
   localparam int PSES_T0_USER_BIT   = 2;
   localparam int PSES_T0_KERNEL_BIT = 3;
   localparam int PSES_TAG_EN_BIT    = 4;
   localparam int PSES_TAG_VAL_LSB   = 5;
   localparam int PSES_TAG_VAL_MSB   = 8;
   localparam int PSES_MASK_LSB      = 9;
   localparam int PSES_MASK_MSB      = 24;
   localparam int PSES_CLASS_LSB     = 25;
   localparam int PSES_CLASS_MSB     = 30;

   // ---------------------------------------------------------------
   // Other field positions
   // ---------------------------------------------------------------
   localparam int PSES_SMP_EN_BIT    = 24;
   localparam int PSES_ABSENT_BIT    = 12;
   localparam int PSES_FEAT_DBG_BIT  = 21;
   localparam int PSES_ST_BUSY_BIT   = 0;
   localparam int PSES_ST_FULL_BIT   = 1;
   localparam int PSES_ST_NEAR_BIT   = 2;
   localparam int PSES_ST_MGMT_BIT   = 3;

   // ---------------------------------------------------------------
   // Event classes that may drive precise sampling
   // ---------------------------------------------------------------
   localparam logic [5:0] PSES_CLASS_EXEC  = 6'h0c;
   localparam logic [5:0] PSES_CLASS_FRONT = 6'h08;
   localparam logic [5:0] PSES_CLASS_REPLAY = 6'h09;

   // ---------------------------------------------------------------
   // Record layout and reset values
   // ---------------------------------------------------------------
   localparam int          PSES_GPR_COUNT    = 8;
   localparam int          PSES_RECORD_WORDS = 10;
   localparam logic [31:0] PSES_WORD_BYTES   = 32'h0000_0004;
   localparam logic [31:0] PSES_RECORD_BYTES = 32'h0000_0028;
   localparam logic [31:0] PSES_RST_WORD     = 32'h0000_0000;

   typedef enum logic [1:0] {
      PSES_ST_IDLE,
      PSES_ST_WRITE,
      PSES_ST_RELOAD
   } pses_state_type;

endpackage

// [src/pses_top.sv]
// Precise sampling engine with its event selector and register port.
//
// Overview of operation
// - On overflow, store registers, flags, pointer record.
// - After storing, reload counter and resume counting.
// - Raise interrupt when record buffer nearly full.
// - Record buffer never wraps around.
// - Sample only execution, front-end, replay classes.
// - Only the one queue counter drives sampling.
// - Identification output sets debug store bit 21.
// - Sampling absent flag reads clear when present.
// - Enable bit 24 turns sampling on or off.
// - Writable save area pointer register exists.
// - Sampling interrupt shares the debug store vector.
// - System management entry disables debug store.
// - Machine check disables; reset and init clear.
// - Debug store works in real address mode.
// - Selector bit 0 counts thread 1 user levels.
// - Selector bit 1 counts thread 1 kernel level.
// - Bits 2, 3 count thread 0 user, kernel.
// - Selector bit 4 enables micro-op tagging.
// - Selector bits 5 to 8 hold tag value.
// - Bits 25-30 pick class, 9-24 mask events.
// - Some sub-events count regardless of thread.
`timescale 1ns/1ps
module pses_top #(
   parameter int          CNT_W             = 40,
   parameter logic [15:0] THREAD_INDEP_MASK = 16'h0000,
   parameter bit          SAMPLING_PRESENT  = 1'b1
) (
   input  wire logic                 clk_sys,
   input  wire logic                 rst_b,
   input  wire logic [7:0]           reg_addr,
   input  wire logic [31:0]          reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output logic [31:0]               reg_rdata,
   input  wire logic                 ev_valid,
   input  wire logic [5:0]           ev_class,
   input  wire logic [15:0]          ev_sub,
   input  wire logic                 ev_thread,
   input  wire logic [1:0]           ev_priv,
   input  wire logic [255:0]         arch_gpr,
   input  wire logic [31:0]          arch_flags,
   input  wire logic [31:0]          arch_ip,
   input  wire logic                 mgmt_entry,
   input  wire logic                 mgmt_active,
   input  wire logic                 mcheck,
   input  wire logic                 init_req,
   output logic                      mem_req,
   output logic [31:0]               mem_addr,
   output logic [31:0]               mem_wdata,
   input  wire logic                 mem_ack,
   output logic                      tag_en,
   output logic [3:0]                tag_value,
   output logic                      store_irq,
   output logic [31:0]               id_features
);
   import pses_pkg::*;

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   pses_state_type state_q;
   logic [31:0]    evsel_q;
   logic           smp_en_q;
   logic [31:0]    area_ptr_q;
   logic [CNT_W-1:0] counter_q;
   logic [CNT_W-1:0] cnt_rst_q;
   logic [31:0]    base_q;
   logic [31:0]    index_q;
   logic [31:0]    max_q;
   logic [31:0]    thr_q;
   logic           full_q;
   logic           irq_q;
   logic [31:0]    rdata_q;
   logic [31:0]    addr_q;
   logic [31:0]    rec_q [PSES_RECORD_WORDS];
   logic [3:0]     word_q;
   logic           count_hit;
   logic           overflow;
   logic           class_ok;
   logic           room_ok;
   logic           sample_go;
   logic           last_word;
   logic           wr_hit_full;
   logic [31:0]    status;

   // ---------------------------------------------------------------
   // Event qualification
   // ---------------------------------------------------------------
   pses_evsel_qual #(
      .THREAD_INDEP_MASK (THREAD_INDEP_MASK)
   ) u_qual (
      .evsel     (evsel_q),
      .ev_valid  (ev_valid),
      .ev_class  (ev_class),
      .ev_sub    (ev_sub),
      .ev_thread (ev_thread),
      .ev_priv   (ev_priv),
      .count_hit (count_hit)
   );

   // ---------------------------------------------------------------
   // Sampling decision
   // ---------------------------------------------------------------
   // This module is the single queue counter; no other counter
   // has a path into the record engine.
   assign overflow = (state_q == PSES_ST_IDLE) & count_hit
                     & (&counter_q);
   assign class_ok = (evsel_q[PSES_CLASS_MSB:PSES_CLASS_LSB]
                        == PSES_CLASS_EXEC) |
                     (evsel_q[PSES_CLASS_MSB:PSES_CLASS_LSB]
                        == PSES_CLASS_FRONT) |
                     (evsel_q[PSES_CLASS_MSB:PSES_CLASS_LSB]
                        == PSES_CLASS_REPLAY);
   // A record must fit below the absolute maximum; nothing wraps.
   assign room_ok  = ((index_q + PSES_RECORD_BYTES) <= max_q);
   // Processor mode other than system management does not gate.
   assign sample_go = overflow & smp_en_q & ~mgmt_active
                      & class_ok & room_ok;
   assign last_word = (word_q == 4'(PSES_RECORD_WORDS - 1));
   assign wr_hit_full = reg_wr & (reg_addr == PSES_OFF_STATUS)
                        & reg_wdata[PSES_ST_FULL_BIT];

   // ---------------------------------------------------------------
   // Record engine state
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= PSES_ST_IDLE;
      end else if (init_req || mcheck || mgmt_entry) begin
         state_q <= PSES_ST_IDLE;
      end else begin
         unique case (state_q)
            PSES_ST_IDLE: begin
               if (sample_go) begin
                  state_q <= PSES_ST_WRITE;
               end
            end
            PSES_ST_WRITE: begin
               if (mem_ack && last_word) begin
                  state_q <= PSES_ST_RELOAD;
               end
            end
            PSES_ST_RELOAD: begin
               state_q <= PSES_ST_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Record capture and memory write
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < PSES_RECORD_WORDS; i++) begin
            rec_q[i] <= PSES_RST_WORD;
         end
         word_q <= 4'h0;
         addr_q <= PSES_RST_WORD;
      end else if (sample_go) begin
         for (int i = 0; i < PSES_GPR_COUNT; i++) begin
            rec_q[i] <= arch_gpr[i*32 +: 32];
         end
         rec_q[PSES_GPR_COUNT]     <= arch_flags;
         rec_q[PSES_GPR_COUNT + 1] <= arch_ip;
         word_q <= 4'h0;
         addr_q <= index_q;
      end else if (state_q == PSES_ST_WRITE && mem_ack) begin
         for (int i = 0; i < PSES_RECORD_WORDS - 1; i++) begin
            rec_q[i] <= rec_q[i + 1];
         end
         word_q <= word_q + 4'h1;
         addr_q <= addr_q + PSES_WORD_BYTES;
      end
   end

   assign mem_req   = (state_q == PSES_ST_WRITE);
   assign mem_addr  = addr_q;
   assign mem_wdata = rec_q[0];

   // ---------------------------------------------------------------
   // Sampling counter
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         counter_q <= '0;
      end else if (init_req) begin
         counter_q <= '0;
      end else if (state_q == PSES_ST_RELOAD) begin
         counter_q <= cnt_rst_q;
      end else if (reg_wr && reg_addr == PSES_OFF_COUNTER) begin
         counter_q <= CNT_W'(reg_wdata);
      end else if (state_q == PSES_ST_IDLE && count_hit) begin
         counter_q <= counter_q + 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Buffer index
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         index_q <= PSES_RST_WORD;
      end else if (init_req) begin
         index_q <= PSES_RST_WORD;
      end else if (state_q == PSES_ST_RELOAD) begin
         index_q <= index_q + PSES_RECORD_BYTES;
      end else if (reg_wr && reg_addr == PSES_OFF_BUF_INDEX) begin
         index_q <= reg_wdata;
      end
   end

   // ---------------------------------------------------------------
   // Enable and event selector
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         smp_en_q <= 1'b0;
      end else if (init_req || mcheck || mgmt_entry) begin
         smp_en_q <= 1'b0;
      end else if (reg_wr && reg_addr == PSES_OFF_SMP_EN) begin
         smp_en_q <= reg_wdata[PSES_SMP_EN_BIT];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         evsel_q <= PSES_RST_WORD;
      end else if (init_req) begin
         evsel_q <= PSES_RST_WORD;
      end else if (reg_wr && reg_addr == PSES_OFF_EVSEL) begin
         evsel_q <= {1'b0, reg_wdata[30:0]};
      end
   end

   assign tag_en    = evsel_q[PSES_TAG_EN_BIT];
   assign tag_value = evsel_q[PSES_TAG_VAL_MSB:PSES_TAG_VAL_LSB];

   // ---------------------------------------------------------------
   // Save area pointer and buffer fields
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         area_ptr_q <= PSES_RST_WORD;
         base_q     <= PSES_RST_WORD;
         max_q      <= PSES_RST_WORD;
         thr_q      <= PSES_RST_WORD;
         cnt_rst_q  <= '0;
      end else if (init_req) begin
         area_ptr_q <= PSES_RST_WORD;
         base_q     <= PSES_RST_WORD;
         max_q      <= PSES_RST_WORD;
         thr_q      <= PSES_RST_WORD;
         cnt_rst_q  <= '0;
      end else if (reg_wr) begin
         if (reg_addr == PSES_OFF_AREA_PTR) begin
            area_ptr_q <= reg_wdata;
         end
         if (reg_addr == PSES_OFF_BUF_BASE) begin
            base_q <= reg_wdata;
         end
         if (reg_addr == PSES_OFF_BUF_MAX) begin
            max_q <= reg_wdata;
         end
         if (reg_addr == PSES_OFF_BUF_THR) begin
            thr_q <= reg_wdata;
         end
         if (reg_addr == PSES_OFF_CNT_RST) begin
            cnt_rst_q <= CNT_W'(reg_wdata);
         end
      end
   end

   // ---------------------------------------------------------------
   // Buffer full flag and interrupt
   // ---------------------------------------------------------------
   // An overflow refused for lack of room sets the flag and wins over a clear.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         full_q <= 1'b0;
      end else if (init_req) begin
         full_q <= 1'b0;
      end else if (overflow && smp_en_q && !room_ok) begin
         full_q <= 1'b1;
      end else if (wr_hit_full) begin
         full_q <= 1'b0;
      end
   end

   // The same line serves every debug store source.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= smp_en_q & (index_q >= thr_q);
      end
   end

   assign store_irq = irq_q;

   // ---------------------------------------------------------------
   // Identification output
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         id_features <= PSES_RST_WORD;
      end else begin
         id_features <= PSES_RST_WORD;
         id_features[PSES_FEAT_DBG_BIT] <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Register read port
   // ---------------------------------------------------------------
   always_comb begin
      status = PSES_RST_WORD;
      status[PSES_ST_BUSY_BIT] = (state_q != PSES_ST_IDLE);
      status[PSES_ST_FULL_BIT] = full_q;
      status[PSES_ST_NEAR_BIT] = irq_q;
      status[PSES_ST_MGMT_BIT] = mgmt_active;
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rdata_q <= PSES_RST_WORD;
      end else if (reg_rd) begin
         rdata_q <= PSES_RST_WORD;
         unique case (reg_addr)
            PSES_OFF_EVSEL:     rdata_q <= evsel_q;
            PSES_OFF_SMP_EN:    rdata_q[PSES_SMP_EN_BIT] <= smp_en_q;
            PSES_OFF_MISC_EN:
               rdata_q[PSES_ABSENT_BIT] <= ~SAMPLING_PRESENT;
            PSES_OFF_AREA_PTR:  rdata_q <= area_ptr_q;
            PSES_OFF_COUNTER:   rdata_q <= counter_q[31:0];
            PSES_OFF_CNT_RST:   rdata_q <= cnt_rst_q[31:0];
            PSES_OFF_BUF_BASE:  rdata_q <= base_q;
            PSES_OFF_BUF_INDEX: rdata_q <= index_q;
            PSES_OFF_BUF_MAX:   rdata_q <= max_q;
            PSES_OFF_BUF_THR:   rdata_q <= thr_q;
            PSES_OFF_STATUS:    rdata_q <= status;
            PSES_OFF_ID_FEAT:   rdata_q <= id_features;
            default:            rdata_q <= PSES_RST_WORD;
         endcase
      end
   end

   assign reg_rdata = rdata_q;

endmodule

// [testbench/pses_mem_model.sv]
// Memory that takes record words, with stalls that vary by address.
`timescale 1ns/1ps
module pses_mem_model (
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   input  wire logic        mem_req,
   input  wire logic [31:0] mem_addr,
   input  wire logic [31:0] mem_wdata,
   output logic             mem_ack
);
   logic [31:0] mem [logic [31:0]];
   logic [1:0]  wait_q;
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         mem_ack <= 1'b0;
         wait_q  <= 2'h0;
      end else begin
         mem_ack <= 1'b0;
         if (mem_req && mem_ack) begin
            mem[mem_addr] = mem_wdata;
            wait_q <= mem_addr[4:3];
         end else if (mem_req && wait_q == 2'h0) begin
            mem_ack <= 1'b1;
         end else if (mem_req) begin
            wait_q <= wait_q - 2'h1;
         end
      end
   end
endmodule

// [testbench/pses_monitor.sv]
// Port checker for the precise sampling and event select block.
`timescale 1ns/1ps
module pses_monitor
   import pses_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        rst_b,
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic        mgmt_entry,
   input wire logic        mcheck,
   input wire logic        init_req,
   input wire logic        mem_req,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   input wire logic        mem_ack,
   input wire logic        tag_en,
   input wire logic [3:0]  tag_value,
   input wire logic        store_irq,
   input wire logic [31:0] id_features
);
   logic [3:0] words_q;
   logic       brk;
   assign brk = mgmt_entry | mcheck | init_req;
   // Counts accepted words of the record in flight.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         words_q <= 4'h0;
      end else if (!mem_req) begin
         words_q <= 4'h0;
      end else if (mem_ack) begin
         words_q <= words_q + 4'h1;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   a_id_feature: assert property (
      $past(rst_b) |-> id_features == 32'h0020_0000)
      else $error("feature word wrong");
   a_req_hold: assert property (
      mem_req && !mem_ack && !brk |=>
      mem_req && $stable(mem_addr) && $stable(mem_wdata))
      else $error("record word not held");
   a_addr_step: assert property (
      mem_req && mem_ack && !brk && words_q < 4'h9 |=>
      mem_req && mem_addr == $past(mem_addr) + 32'h4)
      else $error("record address step wrong");
   a_ten_words: assert property (
      mem_req && mem_ack && words_q == 4'h9 |=> !mem_req [*2])
      else $error("record length wrong");
   a_mgmt_stop: assert property (
      mgmt_entry |=> !mem_req ##1 !store_irq)
      else $error("store active after mode entry");
   a_mcheck_stop: assert property (
      mcheck |=> !mem_req ##1 !store_irq)
      else $error("store active after machine check");
   a_init_clear: assert property (
      init_req |=> !mem_req ##1 !store_irq)
      else $error("store active after init");
   a_tag_track: assert property (
      reg_wr && reg_addr == PSES_OFF_EVSEL && !init_req |=>
      tag_en == $past(reg_wdata[4]) && tag_value == $past(reg_wdata[8:5]))
      else $error("tag outputs wrong");
   a_unmapped_zero: assert property (
      reg_rd && reg_addr > PSES_OFF_ID_FEAT |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   a_absent_clear: assert property (
      reg_rd && reg_addr == PSES_OFF_MISC_EN |=> !reg_rdata[PSES_ABSENT_BIT])
      else $error("absent flag set");
endmodule

bind pses_top pses_monitor pses_monitor_i (.clk_sys, .rst_b, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mgmt_entry, .mcheck,
   .init_req, .mem_req, .mem_addr, .mem_wdata, .mem_ack, .tag_en,
   .tag_value, .store_irq, .id_features);

// [testbench/test_precise_sampling_event_select.sv]
// Self-checking bench for the precise sampling and event select block.
`timescale 1ns/1ps
module test_precise_sampling_event_select;
   import pses_pkg::*;
   localparam logic [31:0] BASE = 32'h0000_1000;
   localparam logic [15:0] TI_MASK = 16'h8000;
   logic         clk_sys, rst_b, reg_wr, reg_rd, ev_valid, ev_thread;
   logic         mgmt_active, mem_req, mem_ack, tag_en, store_irq;
   logic [1:0]   ev_priv;
   logic [2:0]   abort;
   logic [3:0]   tag_value;
   logic [5:0]   ev_class;
   logic [7:0]   reg_addr;
   logic [15:0]  ev_sub;
   logic [31:0]  reg_wdata, reg_rdata, arch_flags, arch_ip, mem_addr;
   logic [31:0]  mem_wdata, id_features, rng, d, sel, ix;
   logic [255:0] arch_gpr;
   int           n_errors, check_count, cyc;
   logic [5:0]   cls [4] = '{PSES_CLASS_EXEC, PSES_CLASS_FRONT,
                             PSES_CLASS_REPLAY, 6'h05};
   logic [5:0]   rc_cls [6] = '{6'h05, PSES_CLASS_EXEC, PSES_CLASS_EXEC,
                                PSES_CLASS_FRONT, PSES_CLASS_REPLAY,
                                PSES_CLASS_EXEC};
   bit           rc_en [6] = '{1, 0, 1, 1, 1, 1};
   bit           rc_ok [6] = '{0, 0, 1, 1, 1, 0};

   pses_top #(.CNT_W(32), .THREAD_INDEP_MASK(TI_MASK)) pses_top_i (
      .clk_sys, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .ev_valid, .ev_class, .ev_sub, .ev_thread, .ev_priv,
      .arch_gpr, .arch_flags, .arch_ip, .mgmt_entry(abort[0]), .mgmt_active,
      .mcheck(abort[1]), .init_req(abort[2]), .mem_req, .mem_addr,
      .mem_wdata, .mem_ack, .tag_en, .tag_value, .store_irq, .id_features);
   pses_mem_model pses_mem_model_i (.clk_sys, .rst_b, .mem_req, .mem_addr,
      .mem_wdata, .mem_ack);

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         conclude();
      end
   end

   function automatic logic [31:0] rnd();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction
   function automatic logic hit(logic [31:0] s, logic [5:0] c,
                                logic [15:0] sb, logic t, logic [1:0] p);
      logic        q;
      logic [15:0] m;
      q = t ? s[{1'b0, p == 2'h0}] : s[{1'b1, p == 2'h0}];
      m = sb & s[24:9];
      return c == s[30:25] && ((|(m & ~TI_MASK) && q) ||
                               (|(m & TI_MASK) && |s[3:0]));
   endfunction
   function automatic logic [31:0] word(int k);
      return k < 8 ? arch_gpr[k*32+:32] : (k == 8 ? arch_flags : arch_ip);
   endfunction
   task automatic chk(logic [31:0] got, logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] v);
      @(posedge clk_sys);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a, output logic [31:0] v);
      @(posedge clk_sys);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      v = reg_rdata;
   endtask
   task automatic rc(logic [7:0] a, logic [31:0] e);
      rd(a, d);
      chk(d, e);
   endtask
   task automatic ev(logic [5:0] c, logic [15:0] s, logic t, logic [1:0] p);
      @(posedge clk_sys);
      ev_valid  <= 1'b1;
      ev_class  <= c;
      ev_sub    <= s;
      ev_thread <= t;
      ev_priv   <= p;
      @(posedge clk_sys);
      ev_valid <= 1'b0;
   endtask
   task automatic conclude();
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      {reg_wr, reg_rd, ev_valid, ev_thread, mgmt_active, abort} = '0;
      {ev_priv, ev_class, reg_addr, ev_sub, reg_wdata} = '0;
      {arch_gpr, arch_flags, arch_ip} = '0;
      {n_errors, check_count, cyc} = '0;
      rng   = 32'd26776;
      rst_b = 1'b0;
      repeat (10) @(posedge clk_sys);
      rst_b <= 1'b1;
      rc(PSES_OFF_ID_FEAT, 32'h0020_0000);
      rc(PSES_OFF_MISC_EN, 32'h0);
      rc(8'h30, 32'h0);
      sel = rnd();
      wr(PSES_OFF_AREA_PTR, sel);
      rc(PSES_OFF_AREA_PTR, sel);
      for (int i = 0; i < 48; i++) begin
         sel = rnd();
         d = rnd();
         sel[30:25] = cls[d[21:20]];
         wr(PSES_OFF_EVSEL, sel);
         wr(PSES_OFF_COUNTER, 32'h0);
         ev(sel[30:25] ^ {5'h0, d[19]}, d[15:0], d[16], d[18:17]);
         chk(32'(tag_en), 32'(sel[4]));
         chk(32'(tag_value), 32'(sel[8:5]));
         rc(PSES_OFF_COUNTER, 32'(hit(sel, sel[30:25] ^ {5'h0, d[19]},
            d[15:0], d[16], d[18:17])));
         rc(PSES_OFF_EVSEL, sel & 32'h7fff_ffff);
      end
      ix = BASE;
      wr(PSES_OFF_BUF_BASE, BASE);
      wr(PSES_OFF_BUF_INDEX, BASE);
      wr(PSES_OFF_BUF_MAX, BASE + 32'd120);
      wr(PSES_OFF_BUF_THR, BASE + 32'd40);
      wr(PSES_OFF_CNT_RST, 32'hffff_fff0);
      for (int i = 0; i < 6; i++) begin
         wr(PSES_OFF_SMP_EN, {7'h0, rc_en[i], 24'h0});
         wr(PSES_OFF_EVSEL, {1'b0, rc_cls[i], 16'hffff, 9'h00f});
         wr(PSES_OFF_COUNTER, 32'hffff_ffff);
         for (int k = 0; k < 8; k++) arch_gpr[k*32+:32] <= rnd();
         arch_flags <= rnd();
         arch_ip    <= rnd();
         ev(rc_cls[i], 16'h0001, 1'b0, 2'h0);
         for (int n = 0; n < 60; n++) begin
            rd(PSES_OFF_STATUS, d);
            if (!d[0]) break;
         end
         chk(32'(d[1]), 32'(i == 5));
         if (rc_ok[i]) begin
            for (int k = 0; k < 10; k++)
               chk(pses_mem_model_i.mem[ix + 32'(4 * k)], word(k));
            ix = ix + 32'd40;
            rc(PSES_OFF_COUNTER, 32'hffff_fff0);
         end
         rc(PSES_OFF_BUF_INDEX, ix);
         chk(32'(store_irq), 32'(rc_en[i] && ix >= BASE + 32'd40));
         rc(PSES_OFF_STATUS, {29'h0, rc_en[i] && ix >= BASE + 32'd40,
            i == 5, 1'b0});
      end
      for (int k = 0; k < 3; k++) begin
         wr(PSES_OFF_BUF_INDEX, BASE);
         wr(PSES_OFF_SMP_EN, 32'h0100_0000);
         wr(PSES_OFF_COUNTER, 32'hffff_ffff);
         ev(PSES_CLASS_EXEC, 16'h0001, 1'b0, 2'h0);
         abort[k]   <= 1'b1;
         mgmt_active <= (k == 0);
         @(posedge clk_sys);
         abort[k] <= 1'b0;
         rc(PSES_OFF_SMP_EN, 32'h0);
         rd(PSES_OFF_STATUS, d);
         chk(32'(d[3]), 32'(k == 0));
         if (k == 0) begin
            wr(PSES_OFF_SMP_EN, 32'h0100_0000);
            wr(PSES_OFF_COUNTER, 32'hffff_ffff);
            ev(PSES_CLASS_EXEC, 16'h0001, 1'b0, 2'h0);
         end
         rc(PSES_OFF_BUF_INDEX, k == 2 ? 32'h0 : BASE);
         mgmt_active <= 1'b0;
      end
      rc(PSES_OFF_ID_FEAT, 32'h0020_0000);
      conclude();
   end
endmodule
